// [include/cclp_cfg.svh]
// Register offsets, field positions, reset values and counts for the clock block
`ifndef CCLP_CFG_SVH
`define CCLP_CFG_SVH

`define CCLP_AW 8
`define CCLP_DW 32
`define CCLP_NGATE 32
`define CCLP_NPINS 66

`define CCLP_OFF_LPCTRL 8'h00
`define CCLP_OFF_PINSEL 8'h04
`define CCLP_OFF_GATE 8'h08
`define CCLP_OFF_TMRCTL 8'h0c
`define CCLP_OFF_LSP 8'h10
`define CCLP_OFF_HSP 8'h14
`define CCLP_OFF_ANACTL 8'h18
`define CCLP_OFF_PLLREQ 8'h1c
`define CCLP_OFF_STATUS 8'h20
`define CCLP_OFF_LPSTAT 8'h24
`define CCLP_OFF_PLLCTL 8'h28
`define CCLP_OFF_PLLMULT 8'h2c
`define CCLP_OFF_PLLSTATE 8'h30
`define CCLP_OFF_SYSDIV 8'h34

`define CCLP_LPM_LSB 0
`define CCLP_LPM_MSB 1
`define CCLP_QUAL_LSB 2
`define CCLP_QUAL_MSB 7
`define CCLP_WAKEIE_BIT 8
`define CCLP_TSRC_LSB 0
`define CCLP_TSRC_MSB 1
`define CCLP_TDIV_LSB 8
`define CCLP_TDIV_MSB 15

`define CCLP_LPM_IDLE 2'h0
`define CCLP_LPM_STANDBY 2'h1
`define CCLP_TSRC_SYS 2'h0
`define CCLP_TSRC_OSC 2'h1
`define CCLP_TSRC_TEN 2'h2

`define CCLP_QUAL_RST 6'h00
`define CCLP_PINSEL_RST 7'h00
`define CCLP_GATE_RST 32'h00000000
`define CCLP_DIV_RST 8'h00
`define CCLP_LSP_RST 8'h02
`define CCLP_HSP_RST 8'h01
`define CCLP_ANADIV_RST 8'h01
`define CCLP_PLLREG_RST 16'h0000
`define CCLP_LPSTAT_RST 8'h00

`define CCLP_PLL_CTL_IX 2'h0
`define CCLP_PLL_MULT_IX 2'h1
`define CCLP_PLL_STATE_IX 2'h2
`define CCLP_PLL_SYSDIV_IX 2'h3

`endif

// [include/cclp_pkg.sv]
// Types shared by the control-core clock and low-power block
package cclp_pkg;

    typedef enum logic [1:0] {
        CCLP_NORMAL = 2'b00,
        CCLP_IDLE = 2'b01,
        CCLP_STANDBY = 2'b10,
        CCLP_WAKING = 2'b11
    } cclp_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cclp_bus_t;

    typedef struct packed {
        logic inputClk;
        logic periphSysClk;
        logic coreClk;
        logic timerTwoClk;
        logic lowSpeedClk;
        logic highSpeedClk;
        logic analogClk;
        logic sharedClk;
    } cclp_clk_en_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } cclp_div_t;

    typedef struct packed {
        cclp_mode_t mode;
        logic [1:0] lpSel;
        logic [5:0] qual;
        logic wakeIntEn;
        logic [6:0] pinSel;
        logic [31:0] gate;
        logic [1:0] tmrSrc;
        logic [7:0] tmrDiv;
        logic [7:0] lspDiv;
        logic [7:0] hspDiv;
        logic [7:0] anaDiv;
        logic pllOwn;
        logic [3:0][15:0] pll;
        logic [7:0] lpStat;
        logic [2:0] dsSync;
        logic dsLvl;
        logic [2:0] pinSync;
        logic pinLvl;
        logic [6:0] qualCnt;
        logic pinQual;
        logic [31:0] rdata;
        cclp_clk_en_t clk;
        logic [31:0] periphEn;
        logic idleStat;
        logic resume;
        logic wakeIsr;
    } cclp_state_t;

endpackage

// [hw/cclp_div.sv]
// Tick divider: passes one of every divVal+1 input ticks
`timescale 1ns/1ps
`include "cclp_cfg.svh"
module cclp_div
    import cclp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tickIn,
    input wire logic [7:0] divVal,
    output logic tickOut
);
    cclp_div_t st_reg;
    cclp_div_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (tickIn) begin
            // Compare with >= so a shrunk divider never overshoots
            if (st_reg.cnt >= divVal) begin
                st_next.cnt = 8'h00;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tickOut = st_reg.tick;
endmodule

// [hw/cclp_top.sv]
// Control-core clock distribution, low-power modes and shared PLL ownership
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cclp_cfg.svh"
module cclp_top
    import cclp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input cclp_bus_t busReq,
    output logic [31:0] rdata,
    input wire logic pllTick,
    input wire logic oscTick,
    input wire logic tenMhzTick,
    input wire logic pllBypass,
    input wire logic srcClockMissing,
    input wire logic pllLocked,
    input wire logic idleInstr,
    input wire logic enabledIrq,
    input wire logic nmiIrq,
    input wire logic ipcIrqOne,
    input wire logic [65:0] wakePins,
    input wire logic masterDeepSleep,
    input wire logic pllWriteReclaim,
    input wire logic masterPllWr,
    input wire logic [1:0] masterPllIx,
    input wire logic [15:0] masterPllData,
    input wire logic analogIfReset,
    input wire logic analogSecReset,
    output cclp_clk_en_t clkEn,
    output logic [31:0] periphClkEn,
    output logic idleStatus,
    output logic wakeIsrReq,
    output logic resumeFetch,
    output cclp_mode_t modeOut,
    output logic pllOwned,
    output logic [3:0][15:0] pllRegs,
    output logic [7:0] lowPowerStatus
);
    cclp_state_t st_reg;
    cclp_state_t st_next;
    logic analogRst;
    logic srcTick;
    logic mainTick;
    logic sysTick;
    logic periphTick;
    logic tmrSrcTick;
    logic tmrTick;
    logic lspTick;
    logic hspTick;
    logic anaTick;
    logic selPin;

    assign analogRst = rst | analogIfReset | analogSecReset;

    // Missing source outranks bypass: the ten MHz tick never stops
    always_comb begin
        if (srcClockMissing) begin
            srcTick = tenMhzTick;
        end else if (pllBypass) begin
            srcTick = oscTick;
        end else begin
            srcTick = pllTick;
        end
    end

    // Divide by one out of reset, as the system divider field is zero
    cclp_div u_sysdiv (
        .mclk(mclk),
        .rst(rst),
        .tickIn(srcTick),
        .divVal(st_reg.pll[`CCLP_PLL_SYSDIV_IX][7:0]),
        .tickOut(mainTick)
    );

    // Deep sleep cuts the core input clock and everything below it
    assign sysTick = mainTick & ~st_reg.dsLvl;
    assign periphTick = sysTick & (st_reg.mode != CCLP_STANDBY);

    // Oscillator and ten MHz timer sources ignore standby and deep sleep
    always_comb begin
        case (st_reg.tmrSrc)
            `CCLP_TSRC_OSC: tmrSrcTick = oscTick;
            `CCLP_TSRC_TEN: tmrSrcTick = tenMhzTick;
            default: tmrSrcTick = periphTick;
        endcase
    end

    cclp_div u_tmrdiv (
        .mclk(mclk),
        .rst(rst),
        .tickIn(tmrSrcTick),
        .divVal(st_reg.tmrDiv),
        .tickOut(tmrTick)
    );

    cclp_div u_lspdiv (
        .mclk(mclk),
        .rst(rst),
        .tickIn(periphTick),
        .divVal(st_reg.lspDiv),
        .tickOut(lspTick)
    );

    cclp_div u_hspdiv (
        .mclk(mclk),
        .rst(rst),
        .tickIn(periphTick),
        .divVal(st_reg.hspDiv),
        .tickOut(hspTick)
    );

    // Analog divider restarts with its register on any analog reset
    cclp_div u_anadiv (
        .mclk(mclk),
        .rst(analogRst),
        .tickIn(sysTick),
        .divVal(st_reg.anaDiv),
        .tickOut(anaTick)
    );

    // Unselected codes at or above the pin count read as quiet
    assign selPin = (st_reg.pinSel < 7'(`CCLP_NPINS)) ? wakePins[st_reg.pinSel] : 1'b0;

    always_comb begin
        st_next = st_reg;
        st_next.resume = 1'b0;
        st_next.wakeIsr = 1'b0;

        // Three-stage synchronisers; a change counts once stages two and three agree
        st_next.dsSync = {st_reg.dsSync[1:0], masterDeepSleep};
        if (st_reg.dsSync[1] == st_reg.dsSync[2]) begin
            st_next.dsLvl = st_reg.dsSync[2];
        end
        st_next.pinSync = {st_reg.pinSync[1:0], selPin};
        if (st_reg.pinSync[1] == st_reg.pinSync[2]) begin
            st_next.pinLvl = st_reg.pinSync[2];
        end

        // Pin must stay high for qual+1 agreed samples before it may wake
        if (st_reg.pinLvl) begin
            if (st_reg.qualCnt < {1'b0, st_reg.qual}) begin
                st_next.qualCnt = st_reg.qualCnt + 7'h01;
            end else begin
                st_next.pinQual = 1'b1;
            end
        end else begin
            st_next.qualCnt = 7'h00;
            st_next.pinQual = 1'b0;
        end

        // Idle instruction outside normal mode is dropped
        case (st_reg.mode)
            CCLP_NORMAL: begin
                if (idleInstr) begin
                    st_next.idleStat = 1'b1;
                    if (st_reg.lpSel == `CCLP_LPM_STANDBY) begin
                        st_next.mode = CCLP_STANDBY;
                    end else begin
                        st_next.mode = CCLP_IDLE;
                    end
                end
            end
            CCLP_IDLE: begin
                if (enabledIrq || nmiIrq) begin
                    st_next.mode = CCLP_WAKING;
                end
            end
            CCLP_STANDBY: begin
                // Only the qualified pin or IPC one may end standby
                if (st_reg.pinQual || ipcIrqOne) begin
                    st_next.mode = CCLP_WAKING;
                end
            end
            CCLP_WAKING: begin
                // Core, input and peripheral clock enables, ISR and fetch all launch here and show together a cycle later
                st_next.mode = CCLP_NORMAL;
                st_next.idleStat = 1'b0;
                st_next.wakeIsr = st_reg.wakeIntEn;
                st_next.resume = 1'b1;
            end
            default: begin
                st_next.mode = CCLP_NORMAL;
            end
        endcase

        // Enables follow the registered mode, so a mode change acts a cycle late
        st_next.clk.inputClk = sysTick & (st_reg.mode != CCLP_STANDBY);
        st_next.clk.periphSysClk = periphTick;
        st_next.clk.coreClk = sysTick & ((st_reg.mode == CCLP_NORMAL) ||
            (st_reg.mode == CCLP_WAKING));
        st_next.clk.timerTwoClk = tmrTick;
        st_next.clk.lowSpeedClk = lspTick;
        st_next.clk.highSpeedClk = hspTick;
        st_next.clk.analogClk = anaTick;
        st_next.clk.sharedClk = sysTick;
        st_next.periphEn = st_reg.gate & {32{periphTick}};

        // Master write path works only while the core does not hold ownership
        if (masterPllWr && !st_reg.pllOwn && (masterPllIx != `CCLP_PLL_STATE_IX)) begin
            st_next.pll[masterPllIx] = masterPllData;
        end
        // Lock flag reaches software one cycle after the input
        st_next.pll[`CCLP_PLL_STATE_IX] = {15'h0000, pllLocked};

        // No wait states: every accepted write lands at the next edge
        if (busReq.wr) begin
            case (busReq.addr)
                `CCLP_OFF_LPCTRL: begin
                    st_next.lpSel = busReq.wdata[`CCLP_LPM_MSB:`CCLP_LPM_LSB];
                    st_next.qual = busReq.wdata[`CCLP_QUAL_MSB:`CCLP_QUAL_LSB];
                    st_next.wakeIntEn = busReq.wdata[`CCLP_WAKEIE_BIT];
                end
                `CCLP_OFF_PINSEL: st_next.pinSel = busReq.wdata[6:0];
                `CCLP_OFF_GATE: st_next.gate = busReq.wdata;
                `CCLP_OFF_TMRCTL: begin
                    st_next.tmrSrc = busReq.wdata[`CCLP_TSRC_MSB:`CCLP_TSRC_LSB];
                    st_next.tmrDiv = busReq.wdata[`CCLP_TDIV_MSB:`CCLP_TDIV_LSB];
                end
                `CCLP_OFF_LSP: st_next.lspDiv = busReq.wdata[7:0];
                `CCLP_OFF_HSP: st_next.hspDiv = busReq.wdata[7:0];
                `CCLP_OFF_ANACTL: st_next.anaDiv = busReq.wdata[7:0];
                `CCLP_OFF_PLLREQ: begin
                    if (busReq.wdata[0]) begin
                        st_next.pllOwn = 1'b1;
                    end
                end
                `CCLP_OFF_LPSTAT: st_next.lpStat = busReq.wdata[7:0];
                `CCLP_OFF_PLLCTL: begin
                    if (st_reg.pllOwn) begin
                        st_next.pll[`CCLP_PLL_CTL_IX] = busReq.wdata[15:0];
                    end
                end
                `CCLP_OFF_PLLMULT: begin
                    if (st_reg.pllOwn) begin
                        st_next.pll[`CCLP_PLL_MULT_IX] = busReq.wdata[15:0];
                    end
                end
                `CCLP_OFF_SYSDIV: begin
                    if (st_reg.pllOwn) begin
                        st_next.pll[`CCLP_PLL_SYSDIV_IX] = busReq.wdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Master may take ownership back at any time, even against a fresh request
        if (pllWriteReclaim) begin
            st_next.pllOwn = 1'b0;
        end

        // Read data stands for one cycle only, zero otherwise
        st_next.rdata = 32'h00000000;
        if (busReq.rd) begin
            case (busReq.addr)
                `CCLP_OFF_LPCTRL: st_next.rdata = {23'h000000, st_reg.wakeIntEn,
                    st_reg.qual, st_reg.lpSel};
                `CCLP_OFF_PINSEL: st_next.rdata = {25'h0000000, st_reg.pinSel};
                `CCLP_OFF_GATE: st_next.rdata = st_reg.gate;
                `CCLP_OFF_TMRCTL: st_next.rdata = {16'h0000, st_reg.tmrDiv, 6'h00,
                    st_reg.tmrSrc};
                `CCLP_OFF_LSP: st_next.rdata = {24'h000000, st_reg.lspDiv};
                `CCLP_OFF_HSP: st_next.rdata = {24'h000000, st_reg.hspDiv};
                `CCLP_OFF_ANACTL: st_next.rdata = {24'h000000, st_reg.anaDiv};
                `CCLP_OFF_PLLREQ: st_next.rdata = {31'h00000000, st_reg.pllOwn};
                `CCLP_OFF_STATUS: st_next.rdata = {26'h0000000, st_reg.pinQual,
                    st_reg.dsLvl, st_reg.idleStat, st_reg.pllOwn, st_reg.mode};
                `CCLP_OFF_LPSTAT: st_next.rdata = {24'h000000, st_reg.lpStat};
                `CCLP_OFF_PLLCTL: st_next.rdata = {16'h0000, st_reg.pll[`CCLP_PLL_CTL_IX]};
                `CCLP_OFF_PLLMULT: st_next.rdata = {16'h0000, st_reg.pll[`CCLP_PLL_MULT_IX]};
                `CCLP_OFF_PLLSTATE: st_next.rdata = {16'h0000,
                    st_reg.pll[`CCLP_PLL_STATE_IX]};
                `CCLP_OFF_SYSDIV: st_next.rdata = {16'h0000,
                    st_reg.pll[`CCLP_PLL_SYSDIV_IX]};
                default: st_next.rdata = 32'h00000000;
            endcase
        end

        // Analog control register follows the analog resets as well as the core reset
        if (analogIfReset || analogSecReset) begin
            st_next.anaDiv = `CCLP_ANADIV_RST;
        end
    end

    // Low-speed, high-speed and analog prescalers leave reset at nonzero defaults; everything else clears
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.mode <= CCLP_NORMAL;
            st_reg.lpSel <= `CCLP_LPM_IDLE;
            st_reg.qual <= `CCLP_QUAL_RST;
            st_reg.pinSel <= `CCLP_PINSEL_RST;
            st_reg.gate <= `CCLP_GATE_RST;
            st_reg.tmrDiv <= `CCLP_DIV_RST;
            st_reg.lspDiv <= `CCLP_LSP_RST;
            st_reg.hspDiv <= `CCLP_HSP_RST;
            st_reg.anaDiv <= `CCLP_ANADIV_RST;
            st_reg.pll <= {4{`CCLP_PLLREG_RST}};
            st_reg.lpStat <= `CCLP_LPSTAT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output comes straight from the state register
    assign rdata = st_reg.rdata;
    assign clkEn = st_reg.clk;
    assign periphClkEn = st_reg.periphEn;
    assign idleStatus = st_reg.idleStat;
    assign wakeIsrReq = st_reg.wakeIsr;
    assign resumeFetch = st_reg.resume;
    assign modeOut = st_reg.mode;
    assign pllOwned = st_reg.pllOwn;
    assign pllRegs = st_reg.pll;
    assign lowPowerStatus = st_reg.lpStat;
endmodule

// [verification/cclp_top_chk.sv]
// Port assertions for the clock and low-power block
`timescale 1ns/1ps
module cclp_top_chk
    import cclp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input cclp_bus_t busReq,
    input wire logic idleInstr,
    input wire logic enabledIrq,
    input wire logic nmiIrq,
    input wire logic ipcIrqOne,
    input wire logic masterDeepSleep,
    input wire logic pllWriteReclaim,
    input wire logic masterPllWr,
    input cclp_clk_en_t clkEn,
    input wire logic idleStatus,
    input wire logic resumeFetch,
    input cclp_mode_t modeOut,
    input wire logic pllOwned,
    input wire logic [3:0][15:0] pllRegs
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Entry cycle skipped: enables launched from normal may land
    a_idle_core_off: assert property (modeOut == CCLP_IDLE && $past(modeOut) == CCLP_IDLE
        |-> !clkEn.coreClk) else $error("core tick in idle");
    a_standby_all_off: assert property (modeOut == CCLP_STANDBY
        && $past(modeOut) == CCLP_STANDBY
        |-> !(clkEn.inputClk || clkEn.periphSysClk || clkEn.coreClk))
        else $error("clock tick in standby");
    a_idle_entry: assert property ($rose(idleStatus)
        |-> $past(idleInstr) && modeOut inside {CCLP_IDLE, CCLP_STANDBY})
        else $error("idle status without idle instruction");
    a_idle_exit: assert property (modeOut == CCLP_IDLE && (enabledIrq || nmiIrq)
        |=> modeOut == CCLP_WAKING) else $error("idle not left on interrupt");
    a_standby_ipc: assert property (modeOut == CCLP_STANDBY && ipcIrqOne
        |=> modeOut == CCLP_WAKING) else $error("standby not left on ipc");
    a_wake_resume: assert property (modeOut == CCLP_WAKING
        |=> modeOut == CCLP_NORMAL && resumeFetch && !idleStatus)
        else $error("no resume after waking");
    a_reclaim_wins: assert property (pllWriteReclaim |=> !pllOwned)
        else $error("ownership kept after reclaim");
    a_pll_guard: assert property (busReq.wr && busReq.addr == 8'h28
        && !pllOwned && !masterPllWr |=> $stable(pllRegs[0]))
        else $error("unowned core write reached pll");
    a_deep_sleep_off: assert property (masterDeepSleep [*8]
        |-> !clkEn.inputClk && !clkEn.analogClk) else $error("tick in deep sleep");
endmodule

bind cclp_top cclp_top_chk i_cclp_top_chk (.mclk, .rst, .busReq, .idleInstr,
    .enabledIrq, .nmiIrq, .ipcIrqOne, .masterDeepSleep, .pllWriteReclaim,
    .masterPllWr, .clkEn, .idleStatus, .resumeFetch, .modeOut, .pllOwned, .pllRegs);

// [verification/cclp_master_model.sv]
// Master-side partner: deep sleep handshake, ipc wake, pll reclaim
`timescale 1ns/1ps
module cclp_master_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sleepReq,
    input wire logic reclaimCmd,
    input wire logic [7:0] lowPowerStatus,
    output logic masterDeepSleep = 1'b0,
    output logic ipcIrqOne = 1'b0,
    output logic pllWriteReclaim = 1'b0
);
    always @(posedge mclk) begin
        pllWriteReclaim <= reclaimCmd & ~rst;
        ipcIrqOne <= 1'b0;
        if (rst) begin
            masterDeepSleep <= 1'b0;
        end else if (sleepReq && lowPowerStatus == 8'h01) begin
            // Sleeps only once the core posted its standby note
            masterDeepSleep <= 1'b1;
        end else if (!sleepReq && masterDeepSleep) begin
            masterDeepSleep <= 1'b0;
            ipcIrqOne <= 1'b1;
        end
    end
endmodule

// [verification/cclp_top_tb.sv]
// Self-checking bench for the clock and low-power block
`timescale 1ns/1ps
module cclp_top_tb
    import cclp_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, pllTick = 1'b0, oscTick = 1'b0, tenMhzTick = 1'b0;
    logic pllLocked = 1'b0, pllBypass = 1'b0, srcClockMissing = 1'b0, idleInstr = 1'b0;
    logic enabledIrq = 1'b0, nmiIrq = 1'b0, sleepReq = 1'b0, reclaimCmd = 1'b0;
    logic masterPllWr = 1'b0, analogIfReset = 1'b0, analogSecReset = 1'b0;
    logic full = 1'b0, gateOn = 1'b0;
    logic [31:0] rdata, periphClkEn, seed = 32'd62528, gateV = 32'h0, seen = 32'h0;
    logic [65:0] wakePins = '0;
    logic [2:0] tickEn = 3'h1;
    logic [1:0] masterPllIx = 2'h0;
    logic [15:0] masterPllData = 16'h0, pv;
    logic idleStatus, wakeIsrReq, resumeFetch, pllOwned, masterDeepSleep, ipcIrqOne;
    logic pllWriteReclaim;
    logic [7:0] lowPowerStatus, ce;
    logic [3:0][15:0] pllRegs;
    cclp_bus_t busReq = '0;
    cclp_clk_en_t clkEn;
    cclp_mode_t modeOut;
    int errCount = 0, checkCount = 0, n;
    logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h3c};
    logic [31:0] rv [10] = '{0, 0, 0, 0, 2, 1, 1, 0, 0, 0};
    logic [7:0] pa [3] = '{8'h10, 8'h14, 8'h18};
    int pb [3] = '{3, 2, 1};
    int pd [3] = '{3, 2, 4};
    assign ce = clkEn;

    cclp_top i_cclp_top (.mclk, .rst, .busReq, .rdata, .pllTick, .oscTick, .tenMhzTick,
        .pllBypass, .srcClockMissing, .pllLocked, .idleInstr, .enabledIrq, .nmiIrq,
        .ipcIrqOne, .wakePins, .masterDeepSleep, .pllWriteReclaim, .masterPllWr,
        .masterPllIx, .masterPllData, .analogIfReset, .analogSecReset, .clkEn,
        .periphClkEn, .idleStatus, .wakeIsrReq, .resumeFetch, .modeOut, .pllOwned,
        .pllRegs, .lowPowerStatus);
    cclp_master_model i_cclp_master_model (.mclk, .rst, .sleepReq, .reclaimCmd,
        .lowPowerStatus, .masterDeepSleep, .ipcIrqOne, .pllWriteReclaim);

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk) busReq <= '0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk) busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk) busReq <= '0;
        #1 chk(rdata, e);
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask

    // Settles in-flight enables before counting
    task automatic cnt(input int b);
        tick(4);
        n = 0;
        repeat (30) begin
            tick(1);
            n += ce[b];
        end
    endtask

    task automatic enter();
        @(posedge mclk) idleInstr <= 1'b1;
        @(posedge mclk) idleInstr <= 1'b0;
        #1;
    endtask

    task automatic resume(input logic isr);
        n = 0;
        while (resumeFetch !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk({modeOut, wakeIsrReq, idleStatus, resumeFetch}, {CCLP_NORMAL, isr, 2'b01});
    endtask

    task automatic closeOut();
        if (errCount == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial forever #20 mclk = ~mclk;

    // Unselected pins toggle so a wrong pin select shows up
    always @(posedge mclk) begin
        seed <= xs(seed);
        pllTick <= tickEn[0] & (full | seed[3]);
        oscTick <= tickEn[1] & (full | seed[5]);
        tenMhzTick <= tickEn[2] & (full | seed[7]);
        pllLocked <= seed[9];
        wakePins[65:6] <= {seed[27:0], seed};
        wakePins[4:0] <= seed[12:8];
        if (gateOn) begin
            seen <= seen | periphClkEn;
            chk(periphClkEn & ~gateV, 32'h0);
        end
    end

    // Roughly twenty times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        closeOut();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rc(ra[i], rv[i]);
        gateV = seed;
        wr(8'h08, gateV);
        rc(8'h08, gateV);
        gateOn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            {srcClockMissing, pllBypass} <= i[1:0];
            wr(8'h0c, {30'h0, i[1:0]});
            tickEn <= 3'h1 << i;
            cnt(0);
            chk(n > 0, 1);
            cnt(4);
            chk(n > 0, 1);
            tickEn <= ~(3'h1 << i);
            cnt(0);
            chk(n, 0);
            cnt(4);
            chk(n, 0);
        end
        {srcClockMissing, pllBypass} <= 2'h0;
        tickEn <= 3'h1;
        full <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(pa[i], pd[i]);
            cnt(pb[i]);
            chk(n >= 30 / (pd[i] + 1) - 1 && n <= 30 / (pd[i] + 1) + 1, 1);
        end
        full <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            wr(8'h18, 32'h7);
            @(posedge mclk) {analogSecReset, analogIfReset} <= 2'h1 << i;
            @(posedge mclk) {analogSecReset, analogIfReset} <= 2'h0;
            rc(8'h18, 32'h1);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, {23'h0, i[0], 6'h0, 2'(i + (i > 0))});
            enter();
            chk(modeOut, CCLP_IDLE);
            cnt(5);
            chk(n, 0);
            cnt(6);
            chk(n > 0, 1);
            @(posedge mclk) {nmiIrq, enabledIrq} <= i[0] ? 2'h2 : 2'h1;
            resume(i[0]);
            {nmiIrq, enabledIrq} <= 2'h0;
        end
        wr(8'h04, 32'h5);
        wr(8'h00, 32'hd);
        enter();
        chk(modeOut, CCLP_STANDBY);
        rc(8'h20, 32'ha);
        for (int b = 5; b < 8; b++) begin
            cnt(b);
            chk(n, 0);
        end
        // Pin glitch shorter than qual+1 plus interrupt noise
        enabledIrq <= 1'b1;
        wakePins[5] <= 1'b1;
        tick(3);
        wakePins[5] <= 1'b0;
        tick(10);
        enabledIrq <= 1'b0;
        chk(modeOut, CCLP_STANDBY);
        wakePins[5] <= 1'b1;
        resume(1'b0);
        wakePins[5] <= 1'b0;
        cnt(7);
        chk(n > 0, 1);
        wr(8'h24, 32'h1);
        tick(1);
        chk(lowPowerStatus, 8'h1);
        enter();
        sleepReq <= 1'b1;
        tick(8);
        cnt(1);
        chk(n, 0);
        cnt(7);
        chk(n, 0);
        cnt(0);
        chk(n, 0);
        sleepReq <= 1'b0;
        resume(1'b0);
        rc(8'h1c, 32'h0);
        wr(8'h28, seed);
        rc(8'h28, 32'h0);
        pv = seed[15:0];
        masterPllData <= pv;
        masterPllWr <= 1'b1;
        tick(1);
        masterPllIx <= 2'h1;
        tick(1);
        masterPllWr <= 1'b0;
        rc(8'h28, {16'h0, pv});
        rc(8'h2c, {16'h0, pv});
        wr(8'h1c, 32'h1);
        rc(8'h1c, 32'h1);
        chk(pllOwned, 1'b1);
        wr(8'h28, {16'h0, ~pv});
        rc(8'h28, {16'h0, ~pv});
        chk(pllRegs[0], {16'h0, ~pv});
        reclaimCmd <= 1'b1;
        tick(1);
        reclaimCmd <= 1'b0;
        tick(2);
        rc(8'h1c, 32'h0);
        chk(pllOwned, 1'b0);
        wr(8'h28, {16'h0, pv});
        rc(8'h28, {16'h0, ~pv});
        chk(seen, gateV);
        closeOut();
    end
endmodule
